// >>> vsup_regs.vh
// register map, field positions, reset values and timing counts of the vt supervisor
`ifndef VSUP_REGS_VH
`define VSUP_REGS_VH
`define VSUP_CLK_NS      5
`define VSUP_EVAL_MS     5
`define VSUP_EVAL_CYC    20'hF4240
`define VSUP_HIST_MS     40
`define VSUP_HIST_N      (`VSUP_HIST_MS / `VSUP_EVAL_MS)
`define VSUP_A_CTRL      8'h00
`define VSUP_A_GRP0      8'h04
`define VSUP_A_GRP1      8'h08
`define VSUP_A_DELAY     8'h0C
`define VSUP_A_STAT      8'h10
`define VSUP_A_REMAIN    8'h14
`define VSUP_A_ISTAT     8'h18
`define VSUP_A_IMASK     8'h1C
`define VSUP_A_CNT_START 8'h20
`define VSUP_A_CNT_BUS   8'h24
`define VSUP_A_CNT_LINE  8'h28
`define VSUP_A_CNT_BLK   8'h2C
`define VSUP_A_RATIO1    8'h30
`define VSUP_A_RATIO2    8'h34
`define VSUP_A_RATIO3    8'h38
`define VSUP_CTRL_BUSCHK 0
`define VSUP_CTRL_LINCHK 1
`define VSUP_CTRL_CNTCLR 2
`define VSUP_CTRL_GRPSEL 3
`define VSUP_GRP_LOW     0
`define VSUP_GRP_HIGH    8
`define VSUP_GRP_ANG     16
`define VSUP_ST_COND     0
`define VSUP_ST_BUS      4
`define VSUP_ST_ALARM    8
`define VSUP_ST_START    9
`define VSUP_IRQ_START   0
`define VSUP_IRQ_BUS     1
`define VSUP_IRQ_LINE    2
`define VSUP_IRQ_BLK     3
`define VSUP_CTRL_RST    32'h0000000B
`define VSUP_GRP_RST     32'h00325005
`define VSUP_DELAY_RST   32'h00000064
`define VSUP_DELAY_MAX   32'h00057E40
`define VSUP_ANG_FULL    12'hE10
`define VSUP_ANG_HALF    12'h708
`define VSUP_ANG_120     12'h4B0
`define VSUP_ANG_240     12'h960
`define VSUP_SEQ_TOL     12'h064
`define VSUP_C_NORMAL    3'h0
`define VSUP_C_START     3'h1
`define VSUP_C_LINEFAIL  3'h2
`define VSUP_C_BUSFAIL   3'h3
`define VSUP_C_BLOCKED   3'h4
`define VSUP_B_DEAD      3'h0
`define VSUP_B_SEQOK     3'h1
`define VSUP_B_SEQREV    3'h2
`define VSUP_B_SEQUNDEF  3'h3
`define VSUP_B_PROBLEM   3'h4
`endif

// >>> vsup_vt_supervisor.v
// vt supervisor: pick-up, bus state, definite-time alarm, counters, axi4-lite registers
`timescale 1ns/10ps
`include "vsup_regs.vh"

// Operation
// - evaluate the channel one to three magnitudes once every 5 ms evaluation tick.
// - derive phase sequence from tracked channel angles for bus state classification.
// - pick-up when one phase is low and two phases are high.
// - low threshold in 0.01 Un steps; high threshold defaults to 0.80 Un.
// - compute each phase magnitude ratio against the high threshold continuously.
// - block voltage pick-up when every angle changed less than limit over 40 ms.
// - bus fuse check option, default yes, watches bus breaker trip input.
// - line fuse check option, default yes, watches line breaker trip input.
// - classify bus as dead, normal, reversed, undefined sequence or problem.
// - report bus problem whenever any pick-up condition holds.
// - expose condition normal, started, line failure, bus failure, blocked.
// - expose remaining time in 5 ms steps, bounded to 1800 s.
// - two setting groups, changeable by software while supervision runs.
// - sample blocking at tick start; block at pick-up gives blocked, not start.
// - definite-time delay between pick-up and alarm.
// - resettable counters of start, bus alarm, line alarm and blocked events.
module vsup_vt_supervisor #(
  parameter [19:0] P_EVAL_CYC = `VSUP_EVAL_CYC
) (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire [15:0] i_channel_one_magnitude,
  input  wire [15:0] i_channel_two_magnitude,
  input  wire [15:0] i_channel_three_magnitude,
  input  wire [15:0] i_channel_four_magnitude,
  input  wire [11:0] i_channel_one_angle,
  input  wire [11:0] i_channel_two_angle,
  input  wire [11:0] i_channel_three_angle,
  input  wire [11:0] i_channel_four_angle,
  input  wire        i_block,
  input  wire        i_bus_breaker_trip_input,
  input  wire        i_line_breaker_trip_input,
  input  wire [7:0]  i_awaddr,
  input  wire        i_awvalid,
  output reg         o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output reg         o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  input  wire [7:0]  i_araddr,
  input  wire        i_arvalid,
  output reg         o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  output reg         o_start,
  output reg         o_alarm,
  output reg         o_blocked,
  output reg         o_bus_transformer_failure,
  output reg         o_line_transformer_failure,
  output reg         o_irq
);

  function [11:0] ang_sub(input [11:0] a, input [11:0] b);
    ang_sub = (a >= b) ? a - b : a + `VSUP_ANG_FULL - b;
  endfunction
  // shorter way round the circle
  function [11:0] ang_dist(input [11:0] a, input [11:0] b);
    ang_dist = (ang_sub(a, b) > `VSUP_ANG_HALF) ? ang_sub(b, a) : ang_sub(a, b);
  endfunction
  function near(input [11:0] x, input [11:0] c);
    near = (x + `VSUP_SEQ_TOL >= c) && (x <= c + `VSUP_SEQ_TOL);
  endfunction
  function [23:0] ratio(input [15:0] mag, input [7:0] thr);
    ratio = (thr == 8'h00) ? 24'hFFFFFF : {mag, 8'h00} / {16'h0000, thr};
  endfunction
  function [31:0] merge(input [31:0] old, input [31:0] val, input [3:0] strb);
    merge = {strb[3] ? val[31:24] : old[31:24], strb[2] ? val[23:16] : old[23:16],
             strb[1] ? val[15:8] : old[15:8], strb[0] ? val[7:0] : old[7:0]};
  endfunction

  localparam [19:0] EVAL_LAST = P_EVAL_CYC - 20'h00001;

  // three-flop input synchronisers for block and breaker trips
  reg  [2:0]  sy1_r, sy2_r, sy3_r, pin_r;
  reg  [19:0] div_r;
  reg         tick_r, aw_ok_r, w_ok_r, ang_still, rd_err;
  reg  [31:0] ctrl_r, grp0_r, grp1_r, delay_r, remain_r, wdata_r;
  reg  [3:0]  imask_r, istat_r, hfill_r, wstrb_r;
  reg  [31:0] cnt_r [0:3];
  reg  [23:0] ratio_r [0:2];
  reg  [11:0] hist_r [0:31];
  reg  [2:0]  hptr_r, cond_r, bus_r;
  reg  [7:0]  awaddr_r;
  reg  [2:0]  cond_nxt, lowc, highc;
  reg  [31:0] remain_nxt, rd_nxt;
  reg  [3:0]  ev_nxt;
  integer     c, ang_i;

  wire [31:0] grp      = ctrl_r[`VSUP_CTRL_GRPSEL] ? grp1_r : grp0_r;
  wire [7:0]  thr_low  = grp[`VSUP_GRP_LOW +: 8];
  wire [7:0]  thr_high = grp[`VSUP_GRP_HIGH +: 8];
  wire [11:0] ang_lim  = {2'b00, grp[`VSUP_GRP_ANG +: 10]};
  wire [15:0] mag0     = i_channel_one_magnitude;
  wire [15:0] mag1     = i_channel_two_magnitude;
  wire [15:0] mag2     = i_channel_three_magnitude;
  wire [47:0] ang_all  = {i_channel_four_angle, i_channel_three_angle, i_channel_two_angle, i_channel_one_angle};
  wire        blk      = pin_r[0];
  wire        wr_go    = aw_ok_r & w_ok_r & ~o_bvalid;
  wire [31:0] wr_val   = wdata_r;
  wire        two_high = (highc[0] & highc[1]) | (highc[0] & highc[2]) | (highc[1] & highc[2]);
  wire        volt_pu  = (|lowc) & two_high & ~ang_still;
  wire        bus_pu   = ctrl_r[`VSUP_CTRL_BUSCHK] & pin_r[1];
  wire        line_pu  = ctrl_r[`VSUP_CTRL_LINCHK] & pin_r[2];
  wire        pu       = volt_pu | bus_pu | line_pu;
  wire [11:0] s12      = ang_sub(ang_all[11:0], ang_all[23:12]);
  wire [11:0] s23      = ang_sub(ang_all[23:12], ang_all[35:24]);
  wire        cnt_clr  = wr_go && awaddr_r == `VSUP_A_CTRL && wstrb_r[0] && wr_val[`VSUP_CTRL_CNTCLR];

  // levels count once the second and third flops agree
  always @(posedge i_clk) begin
    if (i_rst) begin
      {sy1_r, sy2_r, sy3_r, pin_r} <= 12'h000;
    end else begin
      sy1_r <= {i_line_breaker_trip_input, i_bus_breaker_trip_input, i_block};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      pin_r <= (sy2_r & sy3_r) | (pin_r & (sy2_r | sy3_r));
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      div_r  <= 20'h00000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == EVAL_LAST);
      div_r  <= (div_r == EVAL_LAST) ? 20'h00000 : div_r + 20'h00001;
    end
  end

  always @* begin
    lowc      = {mag2 < {8'h00, thr_low}, mag1 < {8'h00, thr_low}, mag0 < {8'h00, thr_low}};
    highc     = {mag2 > {8'h00, thr_high}, mag1 > {8'h00, thr_high}, mag0 > {8'h00, thr_high}};
    // no 40 ms history yet: treat as still, which holds voltage pick-up off
    ang_still = (hfill_r != 4'h8);
    if (hfill_r == 4'h8) begin
      ang_still = 1'b1;
      for (ang_i = 0; ang_i < 4; ang_i = ang_i + 1)
        if (ang_dist(ang_all[ang_i*12 +: 12], hist_r[ang_i*8 + hptr_r]) >= ang_lim)
          ang_still = 1'b0;
    end
  end

  // definite-time supervision condition
  always @* begin
    cond_nxt   = cond_r;
    remain_nxt = remain_r;
    ev_nxt     = 4'h0;
    if (!pu) begin
      cond_nxt   = `VSUP_C_NORMAL;
      remain_nxt = 32'h00000000;
    end else begin
      case (cond_r)
        `VSUP_C_NORMAL: begin
          if (blk) begin
            cond_nxt                = `VSUP_C_BLOCKED;
            ev_nxt[`VSUP_IRQ_BLK]   = 1'b1;
          end else begin
            cond_nxt                = `VSUP_C_START;
            remain_nxt              = delay_r;
            ev_nxt[`VSUP_IRQ_START] = 1'b1;
          end
        end
        `VSUP_C_START: begin
          if (blk) begin
            cond_nxt              = `VSUP_C_BLOCKED;
            remain_nxt            = 32'h00000000;
            ev_nxt[`VSUP_IRQ_BLK] = 1'b1;
          end else if (remain_r <= 32'h00000001) begin
            remain_nxt = 32'h00000000;
            if (line_pu) begin
              cond_nxt               = `VSUP_C_LINEFAIL;
              ev_nxt[`VSUP_IRQ_LINE] = 1'b1;
            end else begin
              cond_nxt              = `VSUP_C_BUSFAIL;
              ev_nxt[`VSUP_IRQ_BUS] = 1'b1;
            end
          end else begin
            remain_nxt = remain_r - 32'h00000001;
          end
        end
        `VSUP_C_LINEFAIL, `VSUP_C_BUSFAIL, `VSUP_C_BLOCKED: cond_nxt = cond_r;
        default:          cond_nxt = `VSUP_C_NORMAL;
      endcase
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      cond_r    <= `VSUP_C_NORMAL;
      bus_r     <= `VSUP_B_DEAD;
      remain_r  <= 32'h00000000;
      {hptr_r, hfill_r, istat_r} <= 11'h0;
      {o_irq, o_start, o_alarm, o_blocked} <= 4'h0;
      {o_bus_transformer_failure, o_line_transformer_failure} <= 2'b00;
      for (c = 0; c < 4; c = c + 1)
        cnt_r[c] <= 32'h00000000;
      for (c = 0; c < 3; c = c + 1)
        ratio_r[c] <= 24'h000000;
    end else begin
      ratio_r[0] <= ratio(mag0, thr_high);
      ratio_r[1] <= ratio(mag1, thr_high);
      ratio_r[2] <= ratio(mag2, thr_high);
      if (tick_r) begin
        cond_r   <= cond_nxt;
        remain_r <= remain_nxt;
        for (c = 0; c < 4; c = c + 1)
          hist_r[c*8 + hptr_r] <= ang_all[c*12 +: 12];
        hptr_r <= hptr_r + 3'h1;
        if (hfill_r != 4'h8)
          hfill_r <= hfill_r + 4'h1;
        if (pu)
          bus_r <= `VSUP_B_PROBLEM;
        else if (&lowc)
          bus_r <= `VSUP_B_DEAD;
        else if (near(s12, `VSUP_ANG_120) && near(s23, `VSUP_ANG_120))
          bus_r <= `VSUP_B_SEQOK;
        else if (near(s12, `VSUP_ANG_240) && near(s23, `VSUP_ANG_240))
          bus_r <= `VSUP_B_SEQREV;
        else
          bus_r <= `VSUP_B_SEQUNDEF;
      end
      // counter clear and a same-tick event together leave a count of 1
      for (c = 0; c < 4; c = c + 1)
        if (tick_r && ev_nxt[c])
          cnt_r[c] <= cnt_clr ? 32'h00000001 : cnt_r[c] + 32'h00000001;
        else if (cnt_clr)
          cnt_r[c] <= 32'h00000000;
      // sticky status: set wins over write-one-to-clear
      if (wr_go && awaddr_r == `VSUP_A_ISTAT && wstrb_r[0])
        istat_r <= (istat_r & ~wr_val[3:0]) | (tick_r ? ev_nxt : 4'h0);
      else if (tick_r)
        istat_r <= istat_r | ev_nxt;
      o_irq     <= |(istat_r & imask_r);
      o_start   <= (cond_r == `VSUP_C_START);
      o_alarm   <= (cond_r == `VSUP_C_LINEFAIL) || (cond_r == `VSUP_C_BUSFAIL);
      o_blocked <= (cond_r == `VSUP_C_BLOCKED);
      o_bus_transformer_failure  <= (cond_r == `VSUP_C_BUSFAIL);
      o_line_transformer_failure <= (cond_r == `VSUP_C_LINEFAIL);
    end
  end

  // settings are live: thresholds and checks take effect at the next tick, a new delay at the next start
  always @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_r  <= `VSUP_CTRL_RST;
      grp0_r  <= `VSUP_GRP_RST;
      grp1_r  <= `VSUP_GRP_RST;
      delay_r <= `VSUP_DELAY_RST;
      imask_r <= 4'h0;
    end else if (wr_go) begin
      case (awaddr_r)
        `VSUP_A_CTRL:  ctrl_r <= merge(ctrl_r, wr_val, wstrb_r) & 32'h0000000B;
        `VSUP_A_GRP0:  grp0_r <= merge(grp0_r, wr_val, wstrb_r) & 32'h03FFFFFF;
        `VSUP_A_GRP1:  grp1_r <= merge(grp1_r, wr_val, wstrb_r) & 32'h03FFFFFF;
        // clamp keeps the countdown inside 1800 s
        `VSUP_A_DELAY: delay_r <= (merge(delay_r, wr_val, wstrb_r) > `VSUP_DELAY_MAX) ?
                                  `VSUP_DELAY_MAX : merge(delay_r, wr_val, wstrb_r);
        `VSUP_A_IMASK: imask_r <= wstrb_r[0] ? wr_val[3:0] : imask_r;
        default:       imask_r <= imask_r;
      endcase
    end
  end

  always @* begin
    rd_err = 1'b0;
    case (i_araddr)
      `VSUP_A_CTRL:      rd_nxt = ctrl_r;
      `VSUP_A_GRP0:      rd_nxt = grp0_r;
      `VSUP_A_GRP1:      rd_nxt = grp1_r;
      `VSUP_A_DELAY:     rd_nxt = delay_r;
      `VSUP_A_STAT:      rd_nxt = {22'h00000, o_start, o_alarm, 1'b0, bus_r, 1'b0, cond_r};
      `VSUP_A_REMAIN:    rd_nxt = remain_r;
      `VSUP_A_ISTAT:     rd_nxt = {28'h0000000, istat_r};
      `VSUP_A_IMASK:     rd_nxt = {28'h0000000, imask_r};
      `VSUP_A_CNT_START: rd_nxt = cnt_r[0];
      `VSUP_A_CNT_BUS:   rd_nxt = cnt_r[1];
      `VSUP_A_CNT_LINE:  rd_nxt = cnt_r[2];
      `VSUP_A_CNT_BLK:   rd_nxt = cnt_r[3];
      `VSUP_A_RATIO1:    rd_nxt = {8'h00, ratio_r[0]};
      `VSUP_A_RATIO2:    rd_nxt = {8'h00, ratio_r[1]};
      `VSUP_A_RATIO3:    rd_nxt = {8'h00, ratio_r[2]};
      default:           {rd_err, rd_nxt} = {1'b1, 32'h00000000};
    endcase
  end

  // axi4-lite: address and data latched independently, one write at a time
  always @(posedge i_clk) begin
    if (i_rst) begin
      {aw_ok_r, w_ok_r, o_awready, o_wready, o_bvalid, o_arready, o_rvalid} <= 7'h0;
      {o_bresp, o_rresp, wstrb_r, awaddr_r} <= 16'h0000;
      wdata_r   <= 32'h00000000;
      o_rdata   <= 32'h00000000;
    end else begin
      o_awready <= ~aw_ok_r & ~o_awready & ~o_bvalid;
      o_wready  <= ~w_ok_r & ~o_wready & ~o_bvalid;
      if (o_awready && i_awvalid) begin
        aw_ok_r  <= 1'b1;
        awaddr_r <= {i_awaddr[7:2], 2'b00};
      end
      if (o_wready && i_wvalid) begin
        w_ok_r  <= 1'b1;
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
      end
      if (wr_go) begin
        aw_ok_r  <= 1'b0;
        w_ok_r   <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= (awaddr_r > `VSUP_A_RATIO3 || awaddr_r == `VSUP_A_STAT ||
                     awaddr_r == `VSUP_A_REMAIN) ? 2'b10 : 2'b00;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
      o_arready <= ~o_arready & ~o_rvalid & i_arvalid;
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_nxt;
        o_rresp  <= rd_err ? 2'b10 : 2'b00;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> vsup_front_end.sv
// far-side model: three-phase angle source for the four voltage channels
`timescale 1ns/10ps
module vsup_front_end (
  input  wire        i_clk,
  input  wire        i_rev,
  input  wire        i_bad,
  input  wire        i_still,
  output wire [11:0] o_ang1,
  output wire [11:0] o_ang2,
  output wire [11:0] o_ang3,
  output wire [11:0] o_ang4
);
  reg  [11:0] base_r = 12'h000;
  // rotates 0.5 deg a cycle so that any 40 ms window sees a real shift
  always @(posedge i_clk) begin
    if (!i_still) begin
      base_r <= (base_r >= 12'hE0B) ? base_r - 12'hE0B : base_r + 12'h005;
    end
  end
  function automatic [11:0] wrap(input [12:0] x);
    return (x >= 13'hE10) ? 12'(x - 13'hE10) : x[11:0];
  endfunction
  assign o_ang1 = base_r;
  assign o_ang2 = wrap(base_r + (i_rev ? 13'h4B0 : 13'h960));
  assign o_ang3 = i_bad ? o_ang2 : wrap(base_r + (i_rev ? 13'h960 : 13'h4B0));
  assign o_ang4 = base_r;
endmodule

// >>> vsup_vt_supervisor_asserts.sv
// port-level assertions for the vt supervisor
`timescale 1ns/10ps
module vsup_sva (
  input wire        i_clk,
  input wire        i_rst,
  input wire        i_arvalid,
  input wire        o_arready,
  input wire        o_awready,
  input wire        o_bvalid,
  input wire        i_bready,
  input wire        o_rvalid,
  input wire [31:0] o_rdata,
  input wire [1:0]  o_rresp,
  input wire        o_start,
  input wire        o_alarm,
  input wire        o_blocked,
  input wire        o_bus_transformer_failure,
  input wire        o_line_transformer_failure
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_alarm_kind: assert property (o_alarm |-> (o_bus_transformer_failure ^ o_line_transformer_failure))
    else $error("alarm without exactly one failure kind");
  a_blocked_excl: assert property (o_blocked |-> !o_start && !o_alarm)
    else $error("blocked together with start or alarm");
  a_alarm_from_start: assert property ($rose(o_alarm) |-> $past(o_start))
    else $error("alarm rose without a preceding start");
  a_start_holds: assert property ($rose(o_start) |-> o_start[*8])
    else $error("start changed between evaluation ticks");
  a_alarm_holds: assert property ($rose(o_alarm) |-> o_alarm[*8])
    else $error("alarm changed between evaluation ticks");
  a_block_not_alarm: assert property ($rose(o_blocked) |-> !$past(o_alarm))
    else $error("blocked entered from an alarm");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  a_rerr_zero: assert property (o_rvalid && o_rresp == 2'b10 |-> o_rdata == 32'h0)
    else $error("error read returned data");
  a_awready_pulse: assert property (o_awready |=> !o_awready)
    else $error("awready held longer than one cycle");
  a_bvalid_drop: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("bvalid stayed after handshake");
endmodule
bind vsup_vt_supervisor vsup_sva i_sva (.i_clk(i_clk), .i_rst(i_rst), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_awready(o_awready), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_start(o_start), .o_alarm(o_alarm),
  .o_blocked(o_blocked), .o_bus_transformer_failure(o_bus_transformer_failure),
  .o_line_transformer_failure(o_line_transformer_failure));

// >>> vsup_vt_supervisor_tb.sv
// self-checking bench for the vt supervisor with a behavioural reference
`timescale 1ns/10ps
module vsup_vt_supervisor_tb;
  localparam int EV = 20;
  reg         i_clk = 1'b0;
  reg         i_rst = 1'b1;
  reg  [15:0] mag [0:3] = '{16'h0, 16'h0, 16'h0, 16'h0};
  reg         blk = 1'b0, btrip = 1'b0, ltrip = 1'b0, rev = 1'b0, bad = 1'b0, still = 1'b0;
  reg  [7:0]  awaddr = 8'h0, araddr = 8'h0;
  reg  [31:0] wdata = 32'h0, d;
  reg         awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  reg  [1:0]  r;
  wire [11:0] a1, a2, a3, a4;
  wire [31:0] rdata;
  wire [1:0]  bresp, rresp;
  wire        awready, wready, bvalid, arready, rvalid, start, alarm, blocked, busf, linef, irq;
  int         errors = 0, total_checks = 0, n, k;
  integer     seed;
  always #2.5 i_clk = ~i_clk;
  vsup_front_end i_fe (.i_clk(i_clk), .i_rev(rev), .i_bad(bad), .i_still(still),
    .o_ang1(a1), .o_ang2(a2), .o_ang3(a3), .o_ang4(a4));
  vsup_vt_supervisor #(.P_EVAL_CYC(20'd20)) i_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_channel_one_magnitude(mag[0]), .i_channel_two_magnitude(mag[1]),
    .i_channel_three_magnitude(mag[2]), .i_channel_four_magnitude(mag[3]),
    .i_channel_one_angle(a1), .i_channel_two_angle(a2), .i_channel_three_angle(a3),
    .i_channel_four_angle(a4), .i_block(blk), .i_bus_breaker_trip_input(btrip),
    .i_line_breaker_trip_input(ltrip), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(1'b1), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(1'b1), .o_start(start),
    .o_alarm(alarm), .o_blocked(blocked), .o_bus_transformer_failure(busf),
    .o_line_transformer_failure(linef), .o_irq(irq));
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tmo;
    n++;
    if (n > 200) begin
      errors++;
      complete_run;
    end
  endtask
  task wr(input [7:0] a, input [31:0] v, input [1:0] er);
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge i_clk);
      tmo;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task rd(input [7:0] a);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge i_clk);
      tmo;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task rc(input [7:0] a, input [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), d, e);
  endtask
  task wt(input int t);
    repeat (t * EV) @(posedge i_clk);
  endtask
  function automatic [31:0] st(input [2:0] c, input [2:0] b, input al, input s);
    return {22'h0, s, al, 1'b0, b, 1'b0, c};
  endfunction
  function automatic bit pickup(int lo, int hi);
    int nl = 0, nh = 0;
    for (int j = 0; j < 3; j++) begin
      nl += (mag[j] < lo);
      nh += (mag[j] > hi);
    end
    return (nl > 0) && (nh >= 2);
  endfunction
  bit [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
  bit [31:0] rv [8] = '{32'hB, 32'h325005, 32'h325005, 32'h64, 32'h0, 32'h0, 32'h0, 32'h0};
  initial begin
    seed = 32'h6abb7d9b;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    for (k = 0; k < 8; k++) rc(ra[k], rv[k]);
    rd(8'h3C);
    chk("unmapped resp", {30'h0, r}, 32'h2);
    wr(8'h10, 32'h1, 2'b10);
    wr(8'h0C, 32'hFFFFFFFF, 2'b00);
    rc(8'h0C, 32'h57E40);
    wr(8'h0C, 32'h3, 2'b00);
    wr(8'h1C, 32'hF, 2'b00);
    for (k = 0; k < 4; k++) mag[k] <= 16'h5A + 16'({$random(seed)} % 20);
    wt(10);
    rc(8'h10, st(3'h0, 3'h1, 1'b0, 1'b0));
    rc(8'h30, mag[0] * 256 / 80);
    rev <= 1'b1;
    wt(2);
    rc(8'h10, st(3'h0, 3'h2, 1'b0, 1'b0));
    rev <= 1'b0;
    bad <= 1'b1;
    wt(2);
    rc(8'h10, st(3'h0, 3'h3, 1'b0, 1'b0));
    bad <= 1'b0;
    $display("test states done");
    mag[0] <= 16'h2;
    n = 0;
    while (!start) begin
      @(posedge i_clk);
      tmo;
    end
    chk("start", start, pickup(5, 80));
    n = 0;
    while (!alarm) begin
      @(posedge i_clk);
      tmo;
    end
    chk("delay", n, 3 * EV);
    chk("bus fail", busf, 1'b1);
    chk("irq", irq, 1'b1);
    rc(8'h10, st(3'h3, 3'h4, 1'b1, 1'b0));
    rc(8'h18, 32'h3);
    rc(8'h20, 32'h1);
    rc(8'h24, 32'h1);
    wr(8'h18, 32'h3, 2'b00);
    repeat (2) @(posedge i_clk);
    chk("irq clear", irq, 1'b0);
    mag[0] <= 16'h5F;
    wt(2);
    chk("alarm off", alarm, 1'b0);
    rc(8'h10, st(3'h0, 3'h1, 1'b0, 1'b0));
    wr(8'h00, 32'hF, 2'b00);
    rc(8'h20, 32'h0);
    $display("test alarm done");
    // blocking raised a full tick ahead of pick-up
    blk <= 1'b1;
    wt(1);
    mag[0] <= 16'h2;
    wt(2);
    chk("blocked", blocked, 1'b1);
    rc(8'h10, st(3'h4, 3'h4, 1'b0, 1'b0));
    rc(8'h2C, 32'h1);
    mag[0] <= 16'h5F;
    blk <= 1'b0;
    still <= 1'b1;
    wt(10);
    mag[0] <= 16'h2;
    wt(2);
    chk("still start", start, 1'b0);
    still <= 1'b0;
    mag[0] <= 16'h5F;
    wt(9);
    ltrip <= 1'b1;
    wt(6);
    chk("line fail", linef, 1'b1);
    ltrip <= 1'b0;
    // let one tick see no pick-up, else the line failure just holds
    wt(2);
    btrip <= 1'b1;
    wt(6);
    chk("bus trip", busf, 1'b1);
    btrip <= 1'b0;
    wr(8'h00, 32'h9, 2'b00);
    ltrip <= 1'b1;
    wt(3);
    chk("line unchecked", start, 1'b0);
    ltrip <= 1'b0;
    $display("test block and trips done");
    wr(8'h04, 32'h325032, 2'b00);
    mag[0] <= 16'h1E;
    wt(2);
    chk("grp1 start", start, pickup(5, 80));
    wr(8'h00, 32'h3, 2'b00);
    wt(2);
    chk("grp0 start", start, pickup(50, 80));
    $display("test groups done");
    complete_run;
  end
endmodule
